// ===== link_bringup_pkg.sv
`default_nettype none
package link_bringup_pkg;
  // Bring-up timing; timeouts and settle time in free-running clock cycles, timer width in bits.
  localparam int unsigned TIMER_WIDTH       = 20;
  localparam int unsigned TX_TIMEOUT_CYCLES = 20000;
  localparam int unsigned RX_TIMEOUT_CYCLES = 40000;
  localparam int unsigned SETTLE_CYCLES     = 4;
  // Retry counter.
  localparam int unsigned RETRY_WIDTH       = 8;
  localparam int unsigned RETRY_MAX         = 255;
  // Reset values.
  localparam logic        LINK_DOWN_RESET   = 1'b1;
  localparam logic [1:0]  SYNC_RESET        = 2'h0;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'h0,
    ST_WAIT_TX = 2'h1,
    ST_WAIT_RX = 2'h3,
    ST_DONE    = 2'h2
  } init_state_t;
endpackage
`default_nettype wire

// ===== link_bringup_init_fsm.sv
// What this block does
// - Sticky link-down set while link down
// - Sticky flag cleared only by its clear input
// - Machine idle after rst_b until a reset-all pulse
// - Transmit completion timeout pulses full reset
// - Then receive timeout pulses receive reset
// - Each retry bumps saturating configuration-only counter
// - Done but data bad pulses receive reset
// - Live link status feeds data-good by default
// - Link status output is live, active high
`default_nettype none
module link_bringup_init_fsm #(
  parameter int unsigned TX_TIMEOUT_CYCLES     = link_bringup_pkg::TX_TIMEOUT_CYCLES,
  parameter int unsigned RX_TIMEOUT_CYCLES     = link_bringup_pkg::RX_TIMEOUT_CYCLES,
  parameter int unsigned RETRY_MAX             = link_bringup_pkg::RETRY_MAX,
  parameter bit          DATA_GOOD_FROM_LINK   = 1'b1,
  parameter bit          SINGLE_PLL            = 1'b0
) (
  // Clock and reset
  input  wire logic                                     clk_sys,
  input  wire logic                                     rst_b,
  // External asynchronous controls
  input  wire logic                                     external_full_reset_in,
  input  wire logic                                     link_down_latched_reset_in,
  // Link health from the combined checker logic
  input  wire logic                                     link_up_in,
  input  wire logic                                     rx_data_good_in,
  // Completion from the reset controller
  input  wire logic                                     tx_reset_done_in,
  input  wire logic                                     rx_reset_done_in,
  // Link indicators
  output logic                                          link_status_out,
  output logic                                          link_down_latched_out,
  // Retry resets to the reset controller
  output logic                                          reset_all_retry_out,
  output logic                                          reset_rx_pll_datapath_out,
  output logic                                          reset_rx_datapath_out,
  // Debug
  output logic                                          init_active_out,
  output logic                                          init_done_out,
  output logic [link_bringup_pkg::RETRY_WIDTH-1:0]      retry_count_out
);

  // Timeouts wider than the timer are cut to its width, so a build must keep
  // them below two to the power of the timer width.
  localparam logic [link_bringup_pkg::TIMER_WIDTH-1:0] TX_LIMIT =
    link_bringup_pkg::TIMER_WIDTH'(TX_TIMEOUT_CYCLES);
  localparam logic [link_bringup_pkg::TIMER_WIDTH-1:0] RX_LIMIT =
    link_bringup_pkg::TIMER_WIDTH'(RX_TIMEOUT_CYCLES);
  localparam logic [link_bringup_pkg::TIMER_WIDTH-1:0] SETTLE =
    link_bringup_pkg::TIMER_WIDTH'(link_bringup_pkg::SETTLE_CYCLES);
  localparam logic [link_bringup_pkg::RETRY_WIDTH-1:0] RETRY_SAT =
    link_bringup_pkg::RETRY_WIDTH'(RETRY_MAX);

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers for the asynchronous pins.

  logic [1:0]                                 rst_all_sync_q;
  logic [1:0]                                 clr_sync_q;
  logic                                       rst_all_prev_q;
  logic                                       rst_all_fall;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rst_all_sync_q <= link_bringup_pkg::SYNC_RESET;
      clr_sync_q     <= link_bringup_pkg::SYNC_RESET;
      rst_all_prev_q <= 1'b0;
    end else begin
      rst_all_sync_q <= {rst_all_sync_q[0], external_full_reset_in};
      clr_sync_q     <= {clr_sync_q[0], link_down_latched_reset_in};
      rst_all_prev_q <= rst_all_sync_q[1];
    end
  end

  // The pin is assumed debounced outside, so one falling edge is one pulse.
  assign rst_all_fall = rst_all_prev_q & ~rst_all_sync_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // Link indicators.

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      link_status_out <= 1'b0;
    end else begin
      link_status_out <= link_up_in;
    end
  end

  // Link down wins over the clear, so a drop during a clear is not lost.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      link_down_latched_out <= link_bringup_pkg::LINK_DOWN_RESET;
    end else if (!link_up_in) begin
      link_down_latched_out <= 1'b1;
    end else if (clr_sync_q[1]) begin
      link_down_latched_out <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Activation and retry counter survive rst_b; only configuration clears them.

  logic                                       active_q = 1'b0;
  logic [link_bringup_pkg::RETRY_WIDTH-1:0]   retry_q  = '0;
  logic                                       retry_pulse;

  always_ff @(posedge clk_sys) begin
    if (rst_all_fall) begin
      active_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (retry_pulse && retry_q != RETRY_SAT) begin
      retry_q <= retry_q + 1'b1;
    end
  end

  assign init_active_out = active_q;
  assign retry_count_out = retry_q;

  ////////////////////////////////////////////////////////////////////////////
  // Initialization state machine.

  link_bringup_pkg::init_state_t              state_q;
  logic [link_bringup_pkg::TIMER_WIDTH-1:0]   timer_q;
  logic                                       data_good;
  logic                                       settled;
  logic                                       tx_timeout;
  logic                                       rx_timeout;
  logic                                       rx_retry;

  // Default build feeds live link health in; tying rx_data_good_in high with
  // the parameter cleared switches the data-quality retries off.
  assign data_good  = DATA_GOOD_FROM_LINK ? link_up_in : rx_data_good_in;
  // Done flags are ignored briefly after a retry, since the controller needs
  // a few cycles before it drops a stale done.
  assign settled    = timer_q >= SETTLE;
  assign tx_timeout = (state_q == link_bringup_pkg::ST_WAIT_TX) && !(tx_reset_done_in && settled)
                      && timer_q >= TX_LIMIT;
  assign rx_timeout = (state_q == link_bringup_pkg::ST_WAIT_RX) && !(rx_reset_done_in && settled)
                      && timer_q >= RX_LIMIT;
  assign rx_retry   = rx_timeout || (state_q == link_bringup_pkg::ST_DONE && !data_good);
  assign retry_pulse = (tx_timeout || rx_retry) && !rst_all_fall;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= link_bringup_pkg::ST_IDLE;
      timer_q <= '0;
    end else if (rst_all_fall) begin
      state_q <= link_bringup_pkg::ST_WAIT_TX;
      timer_q <= '0;
    end else begin
      case (state_q)
        link_bringup_pkg::ST_IDLE: begin
          timer_q <= '0;
        end
        link_bringup_pkg::ST_WAIT_TX: begin
          if (tx_reset_done_in && settled) begin
            state_q <= link_bringup_pkg::ST_WAIT_RX;
            timer_q <= '0;
          end else if (tx_timeout) begin
            timer_q <= '0;
          end else begin
            timer_q <= timer_q + 1'b1;
          end
        end
        link_bringup_pkg::ST_WAIT_RX: begin
          if (rx_reset_done_in && settled) begin
            state_q <= link_bringup_pkg::ST_DONE;
            timer_q <= '0;
          end else if (rx_timeout) begin
            timer_q <= '0;
          end else begin
            timer_q <= timer_q + 1'b1;
          end
        end
        link_bringup_pkg::ST_DONE: begin
          if (!data_good) begin
            state_q <= link_bringup_pkg::ST_WAIT_RX;
          end
          timer_q <= '0;
        end
        default: begin
          state_q <= link_bringup_pkg::ST_IDLE;
          timer_q <= '0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered one-cycle retry pulses.

  // The pulses are registered so the reset controller sees clean requests;
  // the price is one cycle of extra latency after each timeout.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      reset_all_retry_out       <= 1'b0;
      reset_rx_pll_datapath_out <= 1'b0;
      reset_rx_datapath_out     <= 1'b0;
    end else begin
      reset_all_retry_out       <= retry_pulse && tx_timeout;
      reset_rx_pll_datapath_out <= retry_pulse && rx_retry && !SINGLE_PLL;
      reset_rx_datapath_out     <= retry_pulse && rx_retry && SINGLE_PLL;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Completion indicator.

  // Trails the state by one cycle so that, like every other output, it
  // leaves a flip-flop directly.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      init_done_out <= 1'b0;
    end else begin
      init_done_out <= state_q == link_bringup_pkg::ST_DONE;
    end
  end

endmodule
`default_nettype wire

// ===== link_bringup_init_fsm_chk.sv
`default_nettype none
module link_bringup_init_fsm_chk #(
  parameter int unsigned RETRY_MAX           = link_bringup_pkg::RETRY_MAX,
  parameter bit          DATA_GOOD_FROM_LINK = 1'b1,
  parameter bit          SINGLE_PLL          = 1'b0
) (
  // Clock and reset
  input wire logic                                 clk_sys,
  input wire logic                                 rst_b,
  // Watched ports
  input wire logic                                 link_up_in,
  input wire logic                                 link_down_latched_reset_in,
  input wire logic                                 rx_data_good_in,
  input wire logic                                 link_status_out,
  input wire logic                                 link_down_latched_out,
  input wire logic                                 reset_all_retry_out,
  input wire logic                                 reset_rx_pll_datapath_out,
  input wire logic                                 reset_rx_datapath_out,
  input wire logic                                 init_active_out,
  input wire logic                                 init_done_out,
  input wire logic [link_bringup_pkg::RETRY_WIDTH-1:0] retry_count_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic data_good;
  logic rx_retry_pulse;
  // The data-good source and the kind of receive reset follow the build options.
  assign data_good      = DATA_GOOD_FROM_LINK ? link_up_in : rx_data_good_in;
  assign rx_retry_pulse = SINGLE_PLL ? reset_rx_datapath_out : reset_rx_pll_datapath_out;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  sequence rx_retry_s;
    ##[0:2] rx_retry_pulse;
  endsequence
  chk_status_up: assert property (link_up_in |=> link_status_out)
    else $error("status not up");
  chk_down_flag: assert property (!link_up_in |=> !link_status_out && link_down_latched_out)
    else $error("down not flagged");
  chk_clear_only: assert property ($fell(link_down_latched_out) |-> $past(link_down_latched_reset_in, 3))
    else $error("sticky cleared");
  chk_idle_quiet: assert property (!init_active_out |-> !reset_all_retry_out && !init_done_out)
    else $error("active early");
  chk_retry_gap: assert property (reset_all_retry_out |=> !reset_all_retry_out [*8])
    else $error("retry too close");
  chk_rx_kind: assert property (SINGLE_PLL ? !reset_rx_pll_datapath_out : !reset_rx_datapath_out)
    else $error("wrong rx reset");
  chk_count_step: assert property ($changed(retry_count_out) |->
    retry_count_out == $past(retry_count_out) + 1'b1 && retry_count_out <= RETRY_MAX)
    else $error("bad count");
  chk_data_bad: assert property (init_done_out && !data_good |-> rx_retry_s)
    else $error("no rx retry");
endmodule
bind link_bringup_init_fsm link_bringup_init_fsm_chk #(
  .RETRY_MAX(RETRY_MAX),
  .DATA_GOOD_FROM_LINK(DATA_GOOD_FROM_LINK),
  .SINGLE_PLL(SINGLE_PLL)
) u_chk (
  .clk_sys(clk_sys),
  .rst_b(rst_b),
  .link_up_in(link_up_in),
  .link_down_latched_reset_in(link_down_latched_reset_in),
  .rx_data_good_in(rx_data_good_in),
  .link_status_out(link_status_out),
  .link_down_latched_out(link_down_latched_out),
  .reset_all_retry_out(reset_all_retry_out),
  .reset_rx_pll_datapath_out(reset_rx_pll_datapath_out),
  .reset_rx_datapath_out(reset_rx_datapath_out),
  .init_active_out(init_active_out),
  .init_done_out(init_done_out),
  .retry_count_out(retry_count_out)
);
`default_nettype wire

// ===== link_bringup_partner.sv
`default_nettype none
module link_bringup_partner (
  // Requests
  input wire logic clk_sys,
  input wire logic full_reset,
  input wire logic rx_reset,
  // Behaviour
  input wire logic tx_ok,
  input wire logic rx_ok,
  // Completion
  output logic     tx_done,
  output logic     rx_done
);
  timeunit 1ns;
  timeprecision 1ns;
  int tx_t = 0;
  int rx_t = 0;
  // A disabled side never completes, which forces the timeout path.
  always @(posedge clk_sys) begin
    tx_t <= (full_reset || !tx_ok) ? 0 : tx_t + 1;
    rx_t <= (full_reset || rx_reset || !rx_ok || !tx_done) ? 0 : rx_t + 1;
  end
  assign tx_done = tx_t > 6;
  assign rx_done = rx_t > 6;
endmodule
`default_nettype wire

// ===== link_bringup_init_fsm_tb.sv
`default_nettype none
module link_bringup_init_fsm_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 0, rst_b = 0, ext = 0, clr = 0, up = 0, good = 1, tx_ok = 0, rx_ok = 0;
  logic tx_done, rx_done, status, down, rall, rrx, rdp, active, done, up_s, rst_s;
  logic [link_bringup_pkg::RETRY_WIDTH-1:0] cnt;
  localparam int TMO = 20;
  localparam int RMAX = 3;
  logic tx_done_l, rx_done_l, rall_l, rrx_l;
  int n_fail = 0, samples_checked = 0, cyc = 0, n_all = 0, n_rx = 0, t_all = 0, gap = 0, i;
  int n_rx_l = 0, m_cnt = 0;
  link_bringup_init_fsm #(.TX_TIMEOUT_CYCLES(TMO), .RX_TIMEOUT_CYCLES(TMO), .RETRY_MAX(RMAX),
    .DATA_GOOD_FROM_LINK(1'b0)) DUT (.clk_sys(clk_sys), .rst_b(rst_b), .external_full_reset_in(ext),
    .link_down_latched_reset_in(clr), .link_up_in(up), .rx_data_good_in(good), .tx_reset_done_in(tx_done),
    .rx_reset_done_in(rx_done), .link_status_out(status), .link_down_latched_out(down),
    .reset_all_retry_out(rall), .reset_rx_pll_datapath_out(rrx), .reset_rx_datapath_out(rdp),
    .init_active_out(active), .init_done_out(done), .retry_count_out(cnt));
  link_bringup_partner u_partner (.clk_sys(clk_sys), .full_reset(rall | ext), .rx_reset(rrx),
    .tx_ok(tx_ok), .rx_ok(rx_ok), .tx_done(tx_done), .rx_done(rx_done));
  // Delivered build: live link health is the data-good source, the input pin is ignored.
  link_bringup_init_fsm #(.TX_TIMEOUT_CYCLES(TMO), .RX_TIMEOUT_CYCLES(TMO), .RETRY_MAX(RMAX)) DUT_LINK (
    .clk_sys(clk_sys), .rst_b(rst_b), .external_full_reset_in(ext), .link_down_latched_reset_in(clr),
    .link_up_in(up), .rx_data_good_in(1'b0), .tx_reset_done_in(tx_done_l), .rx_reset_done_in(rx_done_l),
    .link_status_out(), .link_down_latched_out(), .reset_all_retry_out(rall_l),
    .reset_rx_pll_datapath_out(rrx_l), .reset_rx_datapath_out(), .init_active_out(), .init_done_out(),
    .retry_count_out());
  link_bringup_partner u_partner_link (.clk_sys(clk_sys), .full_reset(rall_l | ext), .rx_reset(rrx_l),
    .tx_ok(tx_ok), .rx_ok(rx_ok), .tx_done(tx_done_l), .rx_done(rx_done_l));
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t %s", $time, what);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #5;
  endtask
  task automatic pulse_ext();
    ext = 1;
    step(3);
    ext = 0;
  endtask
  initial forever #25 clk_sys = ~clk_sys;
  // Reference model: live status trails the link by one cycle; pulses are counted and timed.
  always @(posedge clk_sys) begin
    up_s = up;
    rst_s = rst_b;
    cyc++;
    // Outputs launched at this edge are read once they have settled.
    #1;
    n_rx += int'(rrx);
    n_rx_l += int'(rrx_l);
    if (rall) begin
      gap = cyc - t_all;
      t_all = cyc;
      n_all++;
    end
    if ((rall || rrx || rdp) && m_cnt < RMAX) m_cnt++;
    cmp(cnt, m_cnt, "retry count");
    cmp(rdp, 1'b0, "datapath-only reset");
    if (rst_s) cmp(status, up_s, "status");
    if (rst_s && !up_s) cmp(down, 1'b1, "sticky set");
    if (cyc == 2000) begin
      n_fail++;
      conclude();
    end
  end
  initial begin
    void'($urandom(32'h59966e63));
    step(8);
    rst_b = 1;
    cmp(down, 1'b1, "sticky at start");
    cmp(cnt, 0, "count at config");
    repeat (40) begin
      up = 1'($urandom_range(1, 0));
      step(1);
    end
    up = 0;
    step(1);
    up = 1;
    step(6);
    cmp(down, 1'b1, "sticky held");
    clr = 1;
    step(6);
    clr = 0;
    cmp(down, 1'b0, "sticky cleared");
    cmp(n_all + n_rx, 0, "retry while idle");
    cmp(active, 1'b0, "idle before pulse");
    pulse_ext();
    step(100);
    cmp(gap, TMO + 1, "tx retry period");
    cmp(n_all >= 4, 1, "tx retries");
    cmp(n_rx, 0, "rx before tx");
    cmp(cnt, 3, "count saturates");
    rst_b = 0;
    step(2);
    rst_b = 1;
    cmp(cnt, 3, "count kept");
    cmp(active, 1'b1, "still active");
    tx_ok = 1;
    n_all = 0;
    pulse_ext();
    step(80);
    cmp(n_all, 0, "tx completes");
    cmp(n_rx >= 3, 1, "rx retries");
    rx_ok = 1;
    i = 0;
    while (done !== 1'b1 && i < 200) begin
      step(1);
      i++;
    end
    cmp(done, 1'b1, "init done");
    n_rx = 0;
    n_rx_l = 0;
    step(50);
    cmp(n_rx, 0, "good tied high");
    cmp(n_rx_l, 0, "link up no retry");
    up = 0;
    step(4);
    cmp(n_rx_l > 0, 1, "link loss retry");
    cmp(n_rx, 0, "link ignored when cleared");
    up = 1;
    good = 0;
    step(4);
    cmp(n_rx > 0, 1, "data bad retry");
    good = 1;
    conclude();
  end
endmodule
`default_nettype wire
